/* servo_ascii_command_parser.v */
// Serial ASCII command interpreter with AHB-Lite register slave
// Operation
// - Frame "!"+code+args+letter+CR, reply "#"+value+CR
// - Demand-current reply signed, -256 to 255
// - Current scale given by separate resolution query
// - Acceleration resolution reply unsigned 32-bit
// - Unit follows motor type linear or stepper
// - Address is segment number over offset
// - Segment-offset command stores low part, acknowledges
// - Segment number 0..255 stored high, acknowledged
// - Motor letter only selects the controller
// - Cyclic run from wanted position restarts
// - Cyclic profile repeats until stop command
// - Stop command ends addressed cyclic profile
// - No motion command while cyclic runs
// - Cyclic start overwrites curve position offset
// - Triggered variant, same format and acknowledge
// - Accept commands only for fitting motor types; demand-position set and demand-current query take any type here
// - Triggered run starts on next rising edge
// - Stop mask bit per motor, pass finishes
// - Acknowledge after every action or set command
// - Motor letters upper case, only A to D
//
// Decided for this implementation: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "servo_cmd_map.vh"
module servo_ascii_command_parser (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        ce,
  // AHB-Lite slave
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output wire        hreadyout,
  output wire        hresp,
  output reg  [31:0] hrdata,
  // Serial byte stream
  input  wire [7:0]  rxData,
  input  wire        rxValid,
  output wire        rxReady,
  output wire [7:0]  txData,
  output wire        txValid,
  input  wire        txReady,
  // Motion side
  input  wire [35:0] demandCurrent,
  input  wire [63:0] wantedPos,
  input  wire [3:0]  profileDone,
  input  wire        trigIn,
  output reg  [15:0] posDemand,
  output reg  [1:0]  posDemandMotor,
  output reg         posDemandWr,
  output reg  [3:0]  profileStart,
  output reg  [15:0] profileCurve,
  output reg  [1:0]  profileMotor,
  output reg  [15:0] curveOffset,
  output reg         curveOffsetWr,
  output wire [23:0] memAddr
);
  localparam P_IDLE  = 7'h01;
  localparam P_C1    = 7'h02;
  localparam P_C2    = 7'h04;
  localparam P_ARG   = 7'h08;
  localparam P_CR    = 7'h10;
  localparam P_EXEC  = 7'h20;
  localparam P_REPLY = 7'h40;
  // Registers
  reg        ctrl_reg;
  reg [7:0]  motorType_reg;
  reg [31:0] accResLin_reg;
  reg [31:0] accResStep_reg;
  reg [31:0] currRes_reg;
  reg [7:0]  segNum_reg;
  reg [15:0] segOfs_reg;
  reg        wrPend_reg;
  reg [7:0]  wrAddr_reg;
  // Parser
  reg [6:0]  st_reg;
  reg [15:0] cmd_reg;
  reg [31:0] acc_reg;
  reg        neg_reg;
  reg        sign_reg;
  reg        digit_reg;
  reg        motorSeen_reg;
  reg [1:0]  motor_reg;
  reg        bad_reg;
  // Cyclic state
  reg [3:0]  running_reg;
  reg [3:0]  armed_reg;
  reg [3:0]  pend_reg;
  reg [3:0]  stopReq_reg;
  reg [15:0] curve_reg [0:3];
  // Execute decisions
  reg        repWith;
  reg        repNeg;
  reg [31:0] repMag;
  reg        doPos;
  reg        doOfs;
  reg        doSeg;
  reg        doRun;
  reg        doArm;
  reg        doStop;
  reg [8:0]  curPick;
  reg [3:0]  svcOne;
  reg [1:0]  svcIdx;
  reg [3:0]  restart;
  integer    k;
  integer    j;
  wire       trigRise;
  wire       serBusy;
  wire       take;
  wire       isDigit;
  wire       isUpper;
  wire [1:0] mType;
  wire       mConf;
  wire       mBusy;
  wire       argU;
  function [8:0] pick9;
    input [35:0] v;
    input [1:0]  m;
    case (m)
      2'h0: pick9 = v[8:0];
      2'h1: pick9 = v[17:9];
      2'h2: pick9 = v[26:18];
      default: pick9 = v[35:27];
    endcase
  endfunction
  function [15:0] pick16;
    input [63:0] v;
    input [1:0]  m;
    case (m)
      2'h0: pick16 = v[15:0];
      2'h1: pick16 = v[31:16];
      2'h2: pick16 = v[47:32];
      default: pick16 = v[63:48];
    endcase
  endfunction
  function [3:0] bit4;
    input [1:0] m;
    bit4 = 4'h1 << m;
  endfunction
  // ========================================================
  // Submodules
  edge_sync trigSync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ce      (ce),
    .pinIn   (trigIn),
    .rise    (trigRise)
  );
  reply_serializer replyOut (
    .clk_sys   (clk_sys),
    .nrst      (nrst),
    .ce        (ce),
    .start     (st_reg == P_EXEC),
    .withValue (repWith),
    .neg       (repNeg),
    .mag       (repMag),
    .busy      (serBusy),
    .txData    (txData),
    .txValid   (txValid),
    .txReady   (txReady)
  );
  // ========================================================
  // Bus slave
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign memAddr = {segNum_reg, segOfs_reg};
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      hrdata <= 32'h00000000;
      ctrl_reg <= `CTRL_RST;
      motorType_reg <= `MOTOR_TYPE_RST;
      accResLin_reg <= `RES_RST;
      accResStep_reg <= `RES_RST;
      currRes_reg <= `RES_RST;
    end else if (ce) begin
      wrPend_reg <= hsel & hready & htrans[`HTRANS_ACT_BIT] & hwrite;
      wrAddr_reg <= haddr[7:0];
      if (wrPend_reg) begin
        case (wrAddr_reg)
          `OFS_CTRL:        ctrl_reg <= hwdata[`CTRL_EN_BIT];
          `OFS_MOTOR_TYPE:  motorType_reg <= hwdata[7:0];
          `OFS_ACCRES_LIN:  accResLin_reg <= hwdata;
          `OFS_ACCRES_STEP: accResStep_reg <= hwdata;
          `OFS_CURR_RES:    currRes_reg <= hwdata;
          default: ;
        endcase
      end
      if (hsel && hready && htrans[`HTRANS_ACT_BIT] && !hwrite) begin
        case (haddr[7:0])
          `OFS_CTRL:        hrdata <= {31'h00000000, ctrl_reg};
          `OFS_MOTOR_TYPE:  hrdata <= {24'h000000, motorType_reg};
          `OFS_ACCRES_LIN:  hrdata <= accResLin_reg;
          `OFS_ACCRES_STEP: hrdata <= accResStep_reg;
          `OFS_CURR_RES:    hrdata <= currRes_reg;
          `OFS_MEM_ADDR:    hrdata <= {8'h00, memAddr};
          `OFS_CYC_STATUS:  hrdata <= {20'h00000, stopReq_reg, pend_reg | armed_reg,
                                       running_reg};
          default:          hrdata <= 32'h00000000;
        endcase
      end
    end
  end
  // ========================================================
  // Character classes and motor lookup
  assign rxReady = ctrl_reg & (st_reg != P_EXEC) & (st_reg != P_REPLY);
  assign take = ce & rxValid & rxReady;
  assign isDigit = (rxData >= `CH_ZERO) && (rxData <= `CH_NINE);
  assign isUpper = (rxData >= `CH_A) && (rxData <= `CH_Z);
  assign mType = motorType_reg[{motor_reg, 1'b0} +: 2];
  assign mConf = mType != `MT_NONE;
  assign mBusy = |((running_reg | armed_reg | pend_reg) & bit4(motor_reg));
  assign argU = digit_reg & ~neg_reg;
  // ========================================================
  // Frame parser
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= P_IDLE;
      cmd_reg <= 16'h0000;
      acc_reg <= 32'h00000000;
      neg_reg <= 1'b0;
      sign_reg <= 1'b0;
      digit_reg <= 1'b0;
      motorSeen_reg <= 1'b0;
      motor_reg <= 2'h0;
      bad_reg <= 1'b0;
    end else if (ce) begin
      case (st_reg)
        P_IDLE: if (take && rxData == `CH_BANG) begin
          acc_reg <= 32'h00000000;
          neg_reg <= 1'b0;
          sign_reg <= 1'b0;
          digit_reg <= 1'b0;
          motorSeen_reg <= 1'b0;
          bad_reg <= 1'b0;
          st_reg <= P_C1;
        end
        P_C1: if (take) begin
          cmd_reg[15:8] <= rxData;
          st_reg <= (rxData == `CH_CR) ? P_IDLE : P_C2;
        end
        P_C2: if (take) begin
          cmd_reg[7:0] <= rxData;
          st_reg <= (rxData == `CH_CR) ? P_IDLE : P_ARG;
        end
        P_ARG: if (take) begin
          if (isDigit) begin
            acc_reg <= (acc_reg << 3) + (acc_reg << 1) + {28'h0000000, rxData[3:0]};
            digit_reg <= 1'b1;
          end else if (rxData == `CH_PLUS || rxData == `CH_MINUS) begin
            bad_reg <= bad_reg | sign_reg | digit_reg;
            sign_reg <= 1'b1;
            neg_reg <= rxData == `CH_MINUS;
          end else if (rxData == `CH_CR) begin
            st_reg <= P_EXEC;
          end else if (isUpper) begin
            bad_reg <= bad_reg | (rxData > `CH_D);
            motor_reg <= rxData[1:0] - 2'h1;
            motorSeen_reg <= 1'b1;
            st_reg <= P_CR;
          end else begin
            bad_reg <= 1'b1;
          end
        end
        P_CR: if (take) begin
          if (rxData == `CH_CR)
            st_reg <= P_EXEC;
          else
            bad_reg <= 1'b1;
        end
        P_EXEC: st_reg <= P_REPLY;
        P_REPLY: if (!serBusy)
          st_reg <= P_IDLE;
        default: st_reg <= P_IDLE;
      endcase
    end
  end
  // ========================================================
  // Command decision
  always @* begin
    repWith = 1'b1;
    repNeg = 1'b0;
    repMag = `ACK_ERR;
    doPos = 1'b0;
    doOfs = 1'b0;
    doSeg = 1'b0;
    doRun = 1'b0;
    doArm = 1'b0;
    doStop = 1'b0;
    curPick = pick9(demandCurrent, motor_reg);
    if (!bad_reg) begin
      case (cmd_reg)
        `CMD_DEMAND_POSITION_SET:
          doPos = motorSeen_reg & digit_reg & ~mBusy;
        `CMD_DEMAND_CURRENT_QUERY: if (motorSeen_reg && !sign_reg && !digit_reg) begin
          repNeg = curPick[8];
          repMag = {23'h000000, curPick[8] ? (~curPick + 9'h001) : curPick};
        end
        `CMD_ACCEL_RES_QUERY: if (motorSeen_reg && !sign_reg && !digit_reg) begin
          if (mType == `MT_LINEAR) begin
            repMag = accResLin_reg;
          end else if (mType == `MT_STEPPER) begin
            repMag = accResStep_reg;
          end
        end
        `CMD_CURRENT_RES_QUERY: if (!motorSeen_reg && argU && acc_reg == `CTRL_ID)
          repMag = currRes_reg;
        `CMD_SEGMENT_OFFSET_SET:
          doOfs = motorSeen_reg & argU & mConf & (acc_reg[31:16] == 16'h0000);
        `CMD_SEGMENT_NUMBER_SET:
          doSeg = motorSeen_reg & argU & mConf & (acc_reg <= `SEG_MAX);
        `CMD_CYCLIC_RUN_FROM_POS:
          doRun = motorSeen_reg & argU & mConf & ~mBusy;
        `CMD_CYCLIC_TRIG_FROM_POS:
          doArm = motorSeen_reg & argU & mConf & ~mBusy;
        `CMD_CYCLIC_STOP:
          doStop = motorSeen_reg & argU & mConf & (acc_reg <= `MASK_MAX);
        default: ;
      endcase
    end
    if (doPos || doOfs || doSeg || doRun || doArm || doStop)
      repWith = 1'b0;
  end
  // ========================================================
  // Pending start service and restarts
  always @* begin
    svcOne = 4'h0;
    svcIdx = 2'h0;
    for (k = 3; k >= 0; k = k - 1) begin
      if (pend_reg[k]) begin
        svcOne = 4'h1 << k;
        svcIdx = k[1:0];
      end
    end
    restart = profileDone & running_reg & ~stopReq_reg;
  end
  // ========================================================
  // Execution and cyclic control
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      segNum_reg <= 8'h00;
      segOfs_reg <= 16'h0000;
      posDemand <= 16'h0000;
      posDemandMotor <= 2'h0;
      posDemandWr <= 1'b0;
      running_reg <= 4'h0;
      armed_reg <= 4'h0;
      pend_reg <= 4'h0;
      stopReq_reg <= 4'h0;
      profileStart <= 4'h0;
      profileCurve <= 16'h0000;
      profileMotor <= 2'h0;
      curveOffset <= 16'h0000;
      curveOffsetWr <= 1'b0;
      for (j = 0; j < 4; j = j + 1)
        curve_reg[j] <= 16'h0000;
    end else if (ce) begin
      posDemandWr <= 1'b0;
      curveOffsetWr <= 1'b0;
      profileStart <= svcOne | restart;
      if (st_reg == P_EXEC) begin
        if (doPos) begin
          posDemand <= neg_reg ? (16'h0000 - acc_reg[15:0]) : acc_reg[15:0];
          posDemandMotor <= motor_reg;
          posDemandWr <= 1'b1;
        end
        if (doOfs)
          segOfs_reg <= acc_reg[15:0];
        if (doSeg)
          segNum_reg <= acc_reg[7:0];
        if (doRun || doArm)
          curve_reg[motor_reg] <= acc_reg[15:0];
      end
      // Stopped profiles end after their current pass
      running_reg <= (running_reg | svcOne) & ~(profileDone & stopReq_reg);
      stopReq_reg <= (stopReq_reg & running_reg & ~profileDone)
                     | ((st_reg == P_EXEC && doStop) ? acc_reg[3:0] & running_reg : 4'h0);
      pend_reg <= (pend_reg & ~svcOne)
                  | (trigRise ? armed_reg : 4'h0)
                  | ((st_reg == P_EXEC && doRun) ? bit4(motor_reg) : 4'h0);
      armed_reg <= (trigRise ? 4'h0 : armed_reg & ~((st_reg == P_EXEC && doStop)
                   ? acc_reg[3:0] : 4'h0))
                   | ((st_reg == P_EXEC && doArm) ? bit4(motor_reg) : 4'h0);
      if (svcOne != 4'h0) begin
        profileCurve <= curve_reg[svcIdx];
        profileMotor <= svcIdx;
        curveOffset <= pick16(wantedPos, svcIdx);
        curveOffsetWr <= 1'b1;
      end
    end
  end
endmodule // servo_ascii_command_parser
`default_nettype wire

/* servo_cmd_map.vh */
// Constants of the servo ASCII command interpreter
`ifndef SERVO_CMD_MAP_VH
`define SERVO_CMD_MAP_VH
// ==========================================================
// Register offsets
`define OFS_CTRL        8'h00
`define OFS_MOTOR_TYPE  8'h04
`define OFS_ACCRES_LIN  8'h08
`define OFS_ACCRES_STEP 8'h0c
`define OFS_CURR_RES    8'h10
`define OFS_MEM_ADDR    8'h14
`define OFS_CYC_STATUS  8'h18
`define HTRANS_ACT_BIT  1
`define CTRL_EN_BIT     0
// ==========================================================
// Reset values
`define CTRL_RST        1'b1
`define MOTOR_TYPE_RST  8'h00
`define RES_RST         32'h00000000
// ==========================================================
// Characters
`define CH_BANG   8'h21
`define CH_HASH   8'h23
`define CH_CR     8'h0d
`define CH_PLUS   8'h2b
`define CH_MINUS  8'h2d
`define CH_ZERO   8'h30
`define CH_NINE   8'h39
`define CH_A      8'h41
`define CH_D      8'h44
`define CH_Z      8'h5a
// ==========================================================
// Command codes
`define CMD_DEMAND_POSITION_SET   16'h5350
`define CMD_DEMAND_CURRENT_QUERY  16'h4143
`define CMD_ACCEL_RES_QUERY       16'h4149
`define CMD_CURRENT_RES_QUERY     16'h4349
`define CMD_SEGMENT_OFFSET_SET    16'h414f
`define CMD_SEGMENT_NUMBER_SET    16'h4153
`define CMD_CYCLIC_RUN_FROM_POS   16'h4341
`define CMD_CYCLIC_TRIG_FROM_POS  16'h4342
`define CMD_CYCLIC_STOP           16'h4353
// ==========================================================
// Motor types, limits, reply codes
`define MT_NONE       2'h0
`define MT_LINEAR     2'h1
`define MT_STEPPER    2'h2
`define MT_SOLENOID   2'h3
`define ACK_ERR       32'h00000001
`define SEG_MAX       32'h000000ff
`define MASK_MAX      32'h0000000f
`define CTRL_ID       32'h00000001
`define DEC_LAST_IDX  4'h9
`endif

/* edge_sync.v */
// Two-stage synchroniser with rising-edge pulse
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
  // Clock and reset
  input  wire clk_sys,
  input  wire nrst,
  input  wire ce,
  // Pin and pulse
  input  wire pinIn,
  output wire rise
);
  reg s1_reg;
  reg s2_reg;
  reg s3_reg;
  // ========================================================
  // Synchroniser
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else if (ce) begin
      s1_reg <= pinIn;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign rise = ce & s2_reg & ~s3_reg;
endmodule // edge_sync
`default_nettype wire

/* reply_serializer.v */
// Reply framer: hash, optional signed decimal, carriage return
`timescale 1ns/1ps
`default_nettype none
`include "servo_cmd_map.vh"
module reply_serializer (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        nrst,
  input  wire        ce,
  // Request
  input  wire        start,
  input  wire        withValue,
  input  wire        neg,
  input  wire [31:0] mag,
  output wire        busy,
  // Byte stream
  output reg  [7:0]  txData,
  output reg         txValid,
  input  wire        txReady
);
  localparam S_IDLE = 5'h01;
  localparam S_HASH = 5'h02;
  localparam S_SIGN = 5'h04;
  localparam S_DIG  = 5'h08;
  localparam S_CR   = 5'h10;
  reg [4:0]  st_reg;
  reg        withV_reg;
  reg        neg_reg;
  reg [31:0] rem_reg;
  reg [3:0]  idx_reg;
  reg [3:0]  dig_reg;
  reg        lead_reg;
  function [31:0] pow10;
    input [3:0] i;
    case (i)
      4'h0: pow10 = 32'h3b9aca00;
      4'h1: pow10 = 32'h05f5e100;
      4'h2: pow10 = 32'h00989680;
      4'h3: pow10 = 32'h000f4240;
      4'h4: pow10 = 32'h000186a0;
      4'h5: pow10 = 32'h00002710;
      4'h6: pow10 = 32'h000003e8;
      4'h7: pow10 = 32'h00000064;
      4'h8: pow10 = 32'h0000000a;
      default: pow10 = 32'h00000001;
    endcase
  endfunction
  assign busy = (st_reg != S_IDLE) | txValid;
  // ========================================================
  // Framing sequencer
  always @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      st_reg <= S_IDLE;
      withV_reg <= 1'b0;
      neg_reg <= 1'b0;
      rem_reg <= 32'h00000000;
      idx_reg <= 4'h0;
      dig_reg <= 4'h0;
      lead_reg <= 1'b0;
      txData <= 8'h00;
      txValid <= 1'b0;
    end else if (ce) begin
      if (txValid && txReady)
        txValid <= 1'b0;
      case (st_reg)
        S_IDLE: if (start) begin
          withV_reg <= withValue;
          neg_reg <= neg & withValue;
          rem_reg <= mag;
          idx_reg <= 4'h0;
          dig_reg <= 4'h0;
          lead_reg <= 1'b0;
          st_reg <= S_HASH;
        end
        S_HASH: if (!txValid) begin
          txData <= `CH_HASH;
          txValid <= 1'b1;
          st_reg <= withV_reg ? (neg_reg ? S_SIGN : S_DIG) : S_CR;
        end
        S_SIGN: if (!txValid) begin
          txData <= `CH_MINUS;
          txValid <= 1'b1;
          st_reg <= S_DIG;
        end
        S_DIG: if (!txValid) begin
          if (rem_reg >= pow10(idx_reg)) begin
            rem_reg <= rem_reg - pow10(idx_reg);
            dig_reg <= dig_reg + 4'h1;
          end else begin
            if (lead_reg || dig_reg != 4'h0 || idx_reg == `DEC_LAST_IDX) begin
              txData <= {4'h3, dig_reg};
              txValid <= 1'b1;
              lead_reg <= 1'b1;
            end
            dig_reg <= 4'h0;
            if (idx_reg == `DEC_LAST_IDX)
              st_reg <= S_CR;
            else
              idx_reg <= idx_reg + 4'h1;
          end
        end
        S_CR: if (!txValid) begin
          txData <= `CH_CR;
          txValid <= 1'b1;
          st_reg <= S_IDLE;
        end
        default: st_reg <= S_IDLE;
      endcase
    end
  end
endmodule // reply_serializer
`default_nettype wire

/* servo_ascii_command_parser_checker.sv */
// Port assertions of the servo ASCII command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "servo_cmd_map.vh"
module servo_ascii_command_parser_checker (
  // Clock and reset
  input wire        clk_sys,
  input wire        nrst,
  // Observed ports
  input wire        hreadyout,
  input wire        hresp,
  input wire        rxReady,
  input wire [7:0]  txData,
  input wire        txValid,
  input wire        txReady,
  input wire        posDemandWr,
  input wire [3:0]  profileStart,
  input wire [1:0]  profileMotor,
  input wire        curveOffsetWr,
  input wire [23:0] memAddr
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  // ==========================================================
  // Properties
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not okay");
  a_tx_hold: assert property (txValid && !txReady |=> txValid && $stable(txData))
    else $error("reply byte dropped");
  a_reply_hash: assert property ($fell(rxReady) |-> ##[1:3] (txValid && txData == `CH_HASH))
    else $error("reply without hash");
  a_rx_closed: assert property (txValid |-> !rxReady)
    else $error("input open during reply");
  a_cr_reopen: assert property (txValid && txReady && txData == `CH_CR |-> ##[1:4] rxReady)
    else $error("input not reopened");
  a_start_single: assert property ($onehot0(profileStart))
    else $error("two starts at once");
  a_ofs_first: assert property (curveOffsetWr |-> profileStart[profileMotor])
    else $error("offset without start");
  a_wr_busy: assert property (posDemandWr |-> !rxReady ##1 !posDemandWr)
    else $error("demand write outside command");
  a_addr_quiet: assert property (rxReady |=> $stable(memAddr))
    else $error("address moved while idle");
endmodule // servo_ascii_command_parser_checker
bind servo_ascii_command_parser servo_ascii_command_parser_checker chk (.clk_sys, .nrst,
  .hreadyout, .hresp, .rxReady, .txData, .txValid, .txReady, .posDemandWr, .profileStart,
  .profileMotor, .curveOffsetWr, .memAddr);
`default_nettype wire

/* host_model.sv */
// Host model: framed commands out, framed replies in
`timescale 1ns/1ps
`default_nettype none
module host_model (
  // Clock
  input  wire        clk_sys,
  // Byte stream
  input  wire        rxReady,
  input  wire [7:0]  txData,
  input  wire        txValid,
  output logic [7:0] rxData,
  output logic       rxValid,
  output logic       txReady
);
  logic        slow = 1'b0;
  logic [63:0] rep;
  int          tmo = 0;
  initial begin
    rxData = 8'hff;
    rxValid = 1'b0;
    txReady = 1'b0;
  end
  // ==========================================================
  // One command, then its reply up to the carriage return
  task automatic cmd(input string s);
    int n;
    logic [7:0] b;
    @(posedge clk_sys);
    for (int i = 0; i < s.len(); i++) begin
      rxData <= s[i];
      rxValid <= 1'b1;
      n = 0;
      do begin @(negedge clk_sys); n++; end while (!rxReady && n < 400);
      if (n >= 400) tmo++;
      @(posedge clk_sys);
    end
    rxData <= ~s[s.len()-1];
    rxValid <= 1'b0;
    rep = 64'h0;
    b = 8'h00;
    n = 0;
    while (b != 8'h0d && n < 4000) begin
      @(posedge clk_sys);
      txReady <= slow ? ~txReady : 1'b1;
      @(negedge clk_sys);
      n++;
      if (txValid && txReady) begin b = txData; rep = {rep[55:0], b}; end
    end
    if (n >= 4000) tmo++;
    @(posedge clk_sys);
  endtask
endmodule // host_model
`default_nettype wire

/* servo_ascii_command_parser_tb.sv */
// Testbench of the servo ASCII command interpreter
`timescale 1ns/1ps
`default_nettype none
`include "servo_cmd_map.vh"
module servo_ascii_command_parser_tb;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [35:0] demandCurrent = 36'h0;
  logic [63:0] wantedPos = 64'h0;
  logic [3:0]  profileDone = 4'h0;
  logic        trigIn = 1'b0;
  wire         hreadyout, hresp, rxReady, rxValid, txValid, txReady, posDemandWr, curveOffsetWr;
  wire  [31:0] hrdata;
  wire  [7:0]  rxData, txData;
  wire  [15:0] posDemand, profileCurve, curveOffset;
  wire  [1:0]  posDemandMotor, profileMotor;
  wire  [3:0]  profileStart;
  wire  [23:0] memAddr;
  int          errors = 0;
  int          tests_run = 0;
  int          st [4];
  int          wrs = 0;
  logic [17:0] lastPos = 18'h0;
  logic [15:0] lastOfs = 16'h0;
  logic [31:0] q;
  always #20 clk_sys = ~clk_sys;
  always @(negedge clk_sys) begin
    for (int m = 0; m < 4; m++) st[m] += profileStart[m];
    if (posDemandWr) begin wrs++; lastPos = {posDemandMotor, posDemand}; end
    if (curveOffsetWr) lastOfs = curveOffset;
  end
  servo_ascii_command_parser uut (.clk_sys, .nrst, .ce(1'b1), .hsel, .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata, .rxData, .rxValid,
    .rxReady, .txData, .txValid, .txReady, .demandCurrent, .wantedPos, .profileDone, .trigIn,
    .posDemand, .posDemandMotor, .posDemandWr, .profileStart, .profileCurve, .profileMotor,
    .curveOffset, .curveOffsetWr, .memAddr);
  host_model host (.clk_sys, .rxReady, .txData, .txValid, .rxData, .rxValid, .txReady);
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    errors += host.tmo;
    if (errors == 0 && tests_run > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    n = 0;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 100);
    q = hrdata;
    if (n >= 100) errors++;
  endtask
  task automatic done(input logic [3:0] m);
    @(posedge clk_sys);
    profileDone <= m;
    @(posedge clk_sys);
    profileDone <= 4'h0;
    repeat (3) @(posedge clk_sys);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_regs;
    bus(0, `OFS_CTRL, 32'h0);
    check(q, 32'h1);
    bus(1, `OFS_MOTOR_TYPE, 32'h39);
    bus(0, `OFS_MOTOR_TYPE, 32'h0);
    check(q, 32'h39);
    bus(1, `OFS_ACCRES_LIN, 32'h3a353);
    bus(1, `OFS_ACCRES_STEP, 32'h1000);
    bus(1, `OFS_CURR_RES, 32'h5b8e);
    bus(1, `OFS_MEM_ADDR, 32'h5);
    bus(0, `OFS_MEM_ADDR, 32'h0);
    check(q, 32'h0);
    bus(0, 8'h40, 32'h0);
    check(q, 32'h0);
  endtask
  task automatic t_query;
    demandCurrent <= {18'h0, 9'h0ff, 9'h100};
    host.cmd("!ACA\015");
    check(host.rep, "#-256\015");
    host.slow = 1'b1;
    host.cmd("!ACB\015");
    check(host.rep, "#255\015");
    host.slow = 1'b0;
    host.cmd("!AIA\015");
    check(host.rep, "#238419\015");
    host.cmd("!AIB\015");
    check(host.rep, "#4096\015");
    host.cmd("!AIC\015");
    check(host.rep, "#1\015");
    host.cmd("!CI1\015");
    check(host.rep, "#23438\015");
  endtask
  task automatic t_seg;
    host.cmd("!AS255B\015");
    check(host.rep, "#\015");
    host.cmd("!AO65534C\015");
    check(host.rep, "#\015");
    check(memAddr, 24'hfffffe);
    host.cmd("!AS256A\015");
    check(host.rep, "#1\015");
    host.cmd("!AS7D\015");
    check(host.rep, "#1\015");
    host.cmd("!AS7E\015");
    check(host.rep, "#1\015");
    host.cmd("!AS7a\015");
    check(host.rep, "#1\015");
    host.cmd("!AS-1A\015");
    check(host.rep, "#1\015");
    host.cmd("!AS+1A\015");
    check(memAddr, 24'h01fffe);
  endtask
  task automatic t_sp;
    host.cmd("!SP+2000B\015");
    check(host.rep, "#\015");
    check(lastPos, 18'h107d0);
    host.cmd("!SP1A2A\015");
    check(host.rep, "#1\015");
    host.cmd("!SP-5A\015");
    check(lastPos, 18'h0fffb);
  endtask
  task automatic t_cyc;
    wantedPos <= 64'h0000_0000_5678_1234;
    host.cmd("!CA7A\015");
    check(host.rep, "#\015");
    check(st[0], 1);
    check(lastOfs, 16'h1234);
    check(profileCurve, 16'h0007);
    done(4'h1);
    check(st[0], 2);
    host.cmd("!SP5A\015");
    check(host.rep, "#1\015");
    check(wrs, 2);
    host.cmd("!CA1D\015");
    check(host.rep, "#1\015");
    host.cmd("!CS1A\015");
    check(host.rep, "#\015");
    done(4'h1);
    check(st[0], 2);
    host.cmd("!CB3B\015");
    check(host.rep, "#\015");
    bus(0, `OFS_CYC_STATUS, 32'h0);
    check(q, 32'h20);
    repeat (20) @(posedge clk_sys);
    check(st[1], 0);
    trigIn <= 1'b1;
    repeat (8) @(posedge clk_sys);
    check(st[1], 1);
    check(lastOfs, 16'h5678);
    check(profileMotor, 2'h1);
    done(4'h2);
    check(st[1], 2);
    host.cmd("!CS2A\015");
    check(host.rep, "#\015");
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    t_regs;
    t_query;
    t_seg;
    t_sp;
    t_cyc;
    finish_test;
  end
  initial begin
    #4000000;
    errors++;
    finish_test;
  end
endmodule // servo_ascii_command_parser_tb
`default_nettype wire
